// ---- hw/cocs_top.sv ----
// What this block does
// (R1) Collect indications, types and currents of enabled stages; report as event log entries.
// (R2) Only the three non-directional and four directional stages are aggregated.
// (R3) Keep latest fault amplitude in a register that software may overwrite.
// (R4) While start or trip is live, report fault type separately.
// (R5) Drive each active phase start or trip flag into the output matrix.
// (R6) Per-phase start flag: 1 while start present, 0 after clearing delay.
// (R7) Combined start flag is OR of the three phase start flags.
// (R8) Hold status after fault ends until the 0..65535 s clearing delay elapses.
// (R9) Combined start rise makes an event when its rise enable is on.
// (R10) Combined start fall makes an event when its fall enable is on.
// (R11) A setting suppresses or allows repeated events for a growing fault.
// (R12) Alarm display shows latest fault current when it is the largest so far.
// (R13) Phase start rise and fall enables apply to all three phases together.
// (R14) Per-phase trip flag: 1 while trip on, 0 after clearing delay.
// (R15) Combined trip flag is OR of the three phase trip flags.
// (R16) After the fault clears, all activated matrix signals release.
module cocs_top #(
    parameter int TICK_CYC = cocs_pkg::TICK_CYCLES
) (
    input wire logic i_clk_sys, // 125 MHz clock
    input wire logic i_rst_n, // async reset, active low
    input wire cocs_pkg::cocs_stage_s [cocs_pkg::NSTAGE-1:0] i_stage, // stages 0-2 nondir, 3-6 dir
    input wire logic [cocs_pkg::ADDR_W-1:0] i_addr, // register byte address
    input wire logic [cocs_pkg::DATA_W-1:0] i_wr_data, // write data
    input wire logic i_wr_en, // write strobe
    input wire logic i_rd_en, // read strobe
    output logic [cocs_pkg::DATA_W-1:0] o_rd_data, // read data, cycle after strobe
    output cocs_pkg::cocs_event_s o_event, // event log entry
    output cocs_pkg::cocs_matrix_s o_matrix, // output matrix sources
    output cocs_pkg::cocs_fault_type_s o_fault_type, // live fault type
    output logic [cocs_pkg::CUR_W-1:0] o_alarm_current, // alarm screen current
    output logic o_alarm_show // alarm screen shows current
);
    import cocs_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;
    logic [DLY_W-1:0] clearing_delay_r;
    logic [CUR_W-1:0] last_fault_current_r;
    logic [CUR_W-1:0] largest_r;
    logic [NPH-1:0] start_flag_r;
    logic [NPH-1:0] trip_flag_r;
    logic [NPH-1:0] start_prev_r;
    logic [NPH-1:0] trip_prev_r;
    logic live_prev_r;
    logic [DLY_W-1:0] sec_cnt_r;
    logic [31:0] div_cnt_r;
    logic [NPH-1:0] raw_start;
    logic [NPH-1:0] raw_trip;
    logic [CUR_W-1:0] agg_cur;
    logic live_any;
    logic release_now;
    logic combined_start_flag;
    logic combined_trip_flag;
    logic cb_start_prev;
    logic cb_trip_prev;
    logic growing;
    logic cur_update;
    logic [EV_W-1:0] ev_nxt;
    logic [DATA_W-1:0] rd_nxt;
    logic wr_last;

    // gather enabled stages only; nothing else feeds this block
    always_comb begin
        raw_start = '0;
        raw_trip = '0;
        agg_cur = '0;
        for (int s = 0; s < NSTAGE; s++) begin
            if (ctrl_r[CTRL_STAGE_EN_LSB+s]) begin // R2
                raw_start = raw_start | i_stage[s].start; // R1
                raw_trip = raw_trip | i_stage[s].trip;
                if ((|i_stage[s].start || |i_stage[s].trip) && i_stage[s].current > agg_cur) begin
                    agg_cur = i_stage[s].current;
                end
            end
        end
    end

    assign live_any = |raw_start || |raw_trip;
    assign combined_start_flag = |start_flag_r; // R7
    assign combined_trip_flag = |trip_flag_r; // R15
    assign cb_start_prev = |start_prev_r;
    assign cb_trip_prev = |trip_prev_r;
    assign release_now = !live_any && (sec_cnt_r == '0); // R8
    assign growing = live_prev_r && live_any && (agg_cur > last_fault_current_r);
    assign cur_update = live_any && (!live_prev_r || agg_cur > last_fault_current_r);
    assign wr_last = i_wr_en && (i_addr == OFS_LAST_FAULT_CURRENT);

    // clearing delay: reload while live, count whole seconds after
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sec_cnt_r <= '0;
            div_cnt_r <= '0;
        end else if (live_any) begin
            sec_cnt_r <= clearing_delay_r; // R8
            div_cnt_r <= '0;
        end else if (sec_cnt_r != '0) begin
            if (div_cnt_r == 32'(TICK_CYC - 1)) begin
                div_cnt_r <= '0;
                sec_cnt_r <= sec_cnt_r - 16'h0001; // R8
            end else begin
                div_cnt_r <= div_cnt_r + 32'h0000_0001;
            end
        end
    end

    // phase flags: set wins, release only on delay expiry
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_flag_r <= '0;
            trip_flag_r <= '0;
        end else if (live_any) begin
            start_flag_r <= start_flag_r | raw_start; // R6
            trip_flag_r <= trip_flag_r | raw_trip; // R14
        end else if (release_now) begin
            start_flag_r <= '0; // R6 R14 R16
            trip_flag_r <= '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_prev_r <= '0;
            trip_prev_r <= '0;
            live_prev_r <= 1'b0;
        end else begin
            start_prev_r <= start_flag_r;
            trip_prev_r <= trip_flag_r;
            live_prev_r <= live_any;
        end
    end

    // event word from flag edges, gated by enables
    always_comb begin
        ev_nxt = '0;
        for (int p = 0; p < NPH; p++) begin
            ev_nxt[EV_PH_START_RISE+p] = start_flag_r[p] && !start_prev_r[p]
                && ctrl_r[CTRL_PH_START_RISE]; // R13
            ev_nxt[EV_PH_START_FALL+p] = !start_flag_r[p] && start_prev_r[p]
                && ctrl_r[CTRL_PH_START_FALL]; // R13
            ev_nxt[EV_PH_TRIP_RISE+p] = trip_flag_r[p] && !trip_prev_r[p]
                && ctrl_r[CTRL_PH_TRIP_RISE];
            ev_nxt[EV_PH_TRIP_FALL+p] = !trip_flag_r[p] && trip_prev_r[p]
                && ctrl_r[CTRL_PH_TRIP_FALL];
        end
        ev_nxt[EV_CB_START_RISE] = combined_start_flag && !cb_start_prev
            && ctrl_r[CTRL_CB_START_RISE]; // R9
        ev_nxt[EV_CB_START_FALL] = !combined_start_flag && cb_start_prev
            && ctrl_r[CTRL_CB_START_FALL]; // R10
        ev_nxt[EV_CB_TRIP_RISE] = combined_trip_flag && !cb_trip_prev
            && ctrl_r[CTRL_CB_TRIP_RISE];
        ev_nxt[EV_CB_TRIP_FALL] = !combined_trip_flag && cb_trip_prev
            && ctrl_r[CTRL_CB_TRIP_FALL];
        // repeated events while the fault grows
        if (growing && !ctrl_r[CTRL_GROW_SUPPRESS]) begin // R11
            ev_nxt[EV_GROWING] = 1'b1;
            if (combined_start_flag && ctrl_r[CTRL_CB_START_RISE]) begin
                ev_nxt[EV_CB_START_RISE] = 1'b1;
            end
            if (combined_trip_flag && ctrl_r[CTRL_CB_TRIP_RISE]) begin
                ev_nxt[EV_CB_TRIP_RISE] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_event <= '0;
        end else begin
            o_event.valid <= |ev_nxt; // R1
            o_event.mask <= ev_nxt;
            o_event.current <= last_fault_current_r;
        end
    end

    // latest and largest fault current; hardware update wins over write
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_fault_current_r <= '0;
        end else if (cur_update) begin
            last_fault_current_r <= agg_cur; // R3
        end else if (wr_last) begin
            last_fault_current_r <= i_wr_data[CUR_W-1:0]; // R3
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            largest_r <= '0;
        end else if (cur_update && agg_cur > largest_r) begin
            largest_r <= agg_cur;
        end else if (i_wr_en && i_addr == OFS_LARGEST_FAULT_CURRENT) begin
            largest_r <= '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alarm_current <= '0;
            o_alarm_show <= 1'b0;
        end else begin
            o_alarm_current <= last_fault_current_r;
            o_alarm_show <= (last_fault_current_r != '0)
                && (last_fault_current_r >= largest_r); // R12
        end
    end

    // matrix and fault type outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_matrix <= '0;
            o_fault_type <= '0;
        end else begin
            o_matrix.start_flags <= start_flag_r; // R5
            o_matrix.trip_flags <= trip_flag_r;
            o_matrix.combined_start_flag <= combined_start_flag;
            o_matrix.combined_trip_flag <= combined_trip_flag;
            o_fault_type.phases <= raw_start | raw_trip; // R4
            o_fault_type.start <= |raw_start;
            o_fault_type.trip <= |raw_trip;
        end
    end

    // register writes
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= CTRL_RESET;
            clearing_delay_r <= CLEARING_DELAY_RESET;
        end else if (i_wr_en) begin
            if (i_addr == OFS_CTRL) begin
                ctrl_r <= i_wr_data[CTRL_W-1:0];
            end
            if (i_addr == OFS_CLEARING_DELAY) begin
                clearing_delay_r <= i_wr_data[DLY_W-1:0];
            end
        end
    end

    always_comb begin
        rd_nxt = '0;
        case (i_addr)
            OFS_CTRL: rd_nxt[CTRL_W-1:0] = ctrl_r;
            OFS_CLEARING_DELAY: rd_nxt[DLY_W-1:0] = clearing_delay_r;
            OFS_LAST_FAULT_CURRENT: rd_nxt[CUR_W-1:0] = last_fault_current_r;
            OFS_STATUS: rd_nxt[7:0] = {combined_trip_flag, trip_flag_r,
                combined_start_flag, start_flag_r};
            OFS_LARGEST_FAULT_CURRENT: rd_nxt[CUR_W-1:0] = largest_r;
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= rd_nxt;
        end else begin
            o_rd_data <= '0;
        end
    end

    default clocking cb_main @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_start_flag_set: assert property ( // R6
        raw_start[0] |=> start_flag_r[0])
        else $error("phase start flag not set by live start");

    a_start_combined_or: assert property ( // R7
        o_matrix.combined_start_flag == $past(|start_flag_r))
        else $error("combined start flag is not the OR of phase flags");

    a_delay_hold: assert property ( // R8
        (!live_any && sec_cnt_r != '0 && start_flag_r != '0) |=> start_flag_r == $past(start_flag_r))
        else $error("start flags changed before clearing delay expired");

    a_release_clears: assert property ( // R16
        (!live_any && sec_cnt_r == '0) |=> (start_flag_r == '0 && trip_flag_r == '0)
            ##1 (o_matrix == '0 || $past(live_any)))
        else $error("matrix signals not released after delay");

    a_rise_event_on: assert property ( // R9
        (combined_start_flag && !cb_start_prev && ctrl_r[CTRL_CB_START_RISE])
            |=> o_event.valid && o_event.mask[EV_CB_START_RISE])
        else $error("combined start rise event missing");

    a_fall_event_on: assert property ( // R10
        (!combined_start_flag && cb_start_prev && ctrl_r[CTRL_CB_START_FALL])
            |=> o_event.valid && o_event.mask[EV_CB_START_FALL])
        else $error("combined start fall event missing");

    a_phase_event_gate: assert property ( // R13
        !ctrl_r[CTRL_PH_START_RISE] |=> o_event.mask[EV_PH_START_RISE+:NPH] == '0)
        else $error("phase start event with enable off");

    a_trip_flag_set: assert property ( // R14
        raw_trip[2] |=> trip_flag_r[2] ##1 o_matrix.trip_flags[2])
        else $error("phase trip flag not set and driven");

    a_trip_combined_or: assert property ( // R15
        o_matrix.combined_trip_flag == $past(|trip_flag_r))
        else $error("combined trip flag is not the OR of phase flags");

    a_grow_suppress: assert property ( // R11
        ctrl_r[CTRL_GROW_SUPPRESS] |=> !o_event.mask[EV_GROWING])
        else $error("growing fault event despite suppression");

    a_stage_gating: assert property ( // R2
        (ctrl_r[CTRL_W-1:CTRL_STAGE_EN_LSB] == '0) |-> !live_any)
        else $error("disabled stages reached the aggregation");

    a_last_current_write: assert property ( // R3
        (wr_last && !cur_update) |=> last_fault_current_r == $past(i_wr_data[CUR_W-1:0]))
        else $error("software write of last fault current lost");

    a_fault_type_live: assert property ( // R4
        live_any |=> o_fault_type.phases != '0)
        else $error("fault type not shown while fault live");

    a_alarm_largest: assert property ( // R12
        (last_fault_current_r != '0 && last_fault_current_r >= largest_r) |=> o_alarm_show)
        else $error("alarm display does not show largest current");

    a_cb_rise_gate: assert property ( // R9
        !ctrl_r[CTRL_CB_START_RISE] |=> !o_event.mask[EV_CB_START_RISE])
        else $error("combined start rise event with enable off");

    a_matrix_follows: assert property ( // R5
        o_matrix.start_flags == $past(start_flag_r)
            && o_matrix.trip_flags == $past(trip_flag_r))
        else $error("matrix phase signals do not follow the flags");

    a_grow_event_on: assert property ( // R11
        (growing && !ctrl_r[CTRL_GROW_SUPPRESS]) |=> o_event.valid && o_event.mask[EV_GROWING])
        else $error("growing fault event missing");

    a_fault_type_clear: assert property ( // R4
        !live_any |=> o_fault_type == '0)
        else $error("fault type shown with no live fault");

    a_event_current: assert property ( // R1
        o_event.current == $past(last_fault_current_r))
        else $error("event entry does not carry the last fault current");

    c_start_rise: cover property (ev_nxt[EV_CB_START_RISE] ##[1:20] ev_nxt[EV_CB_TRIP_RISE]);
    c_release: cover property (combined_start_flag ##1 !combined_start_flag);
    c_growing: cover property (ev_nxt[EV_GROWING]);
    c_rd_status: cover property (i_rd_en && i_addr == OFS_STATUS);
    c_delay_hold: cover property (!live_any && sec_cnt_r != '0 && start_flag_r != '0);
endmodule // cocs_top

// ---- inc/cocs_pkg.sv ----
package cocs_pkg;
    localparam int NPH = 3;
    localparam int N_NONDIR = 3;
    localparam int N_DIR = 4;
    localparam int NSTAGE = N_NONDIR + N_DIR;
    localparam int CUR_W = 16;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EV_W = 17;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLEARING_DELAY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LAST_FAULT_CURRENT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_LARGEST_FAULT_CURRENT = 8'h10;

    // control register fields
    localparam int CTRL_PH_START_RISE = 0;
    localparam int CTRL_PH_START_FALL = 1;
    localparam int CTRL_CB_START_RISE = 2;
    localparam int CTRL_CB_START_FALL = 3;
    localparam int CTRL_PH_TRIP_RISE = 4;
    localparam int CTRL_PH_TRIP_FALL = 5;
    localparam int CTRL_CB_TRIP_RISE = 6;
    localparam int CTRL_CB_TRIP_FALL = 7;
    localparam int CTRL_GROW_SUPPRESS = 8;
    localparam int CTRL_STAGE_EN_LSB = 16;
    localparam int CTRL_W = CTRL_STAGE_EN_LSB + NSTAGE;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 23'h7f00ff;
    localparam logic [DLY_W-1:0] CLEARING_DELAY_RESET = 16'h0000;

    // event mask bit positions
    localparam int EV_PH_START_RISE = 0;
    localparam int EV_PH_START_FALL = 3;
    localparam int EV_CB_START_RISE = 6;
    localparam int EV_CB_START_FALL = 7;
    localparam int EV_PH_TRIP_RISE = 8;
    localparam int EV_PH_TRIP_FALL = 11;
    localparam int EV_CB_TRIP_RISE = 14;
    localparam int EV_CB_TRIP_FALL = 15;
    localparam int EV_GROWING = 16;

    // timing
    localparam longint CLK_PERIOD_PS = 8000;
    localparam longint SECOND_PS = 1000000000000;
    localparam int TICK_CYCLES = int'(SECOND_PS / CLK_PERIOD_PS);

    typedef struct packed {
        logic [NPH-1:0] start;
        logic [NPH-1:0] trip;
        logic [CUR_W-1:0] current;
    } cocs_stage_s;

    typedef struct packed {
        logic valid;
        logic [EV_W-1:0] mask;
        logic [CUR_W-1:0] current;
    } cocs_event_s;

    typedef struct packed {
        logic trip;
        logic start;
        logic [NPH-1:0] phases;
    } cocs_fault_type_s;

    typedef struct packed {
        logic combined_trip_flag;
        logic combined_start_flag;
        logic [NPH-1:0] trip_flags;
        logic [NPH-1:0] start_flags;
    } cocs_matrix_s;
endpackage

// ---- tb/cocs_stage_model.sv ----
module cocs_stage_model (
    input wire logic i_clk_sys, // clock
    input wire logic i_rst_n, // reset, active low
    input wire logic i_cmd_en, // load one stage
    input wire logic [2:0] i_cmd_idx, // stage index
    input wire cocs_pkg::cocs_stage_s i_cmd, // new indications of that stage
    output cocs_pkg::cocs_stage_s [cocs_pkg::NSTAGE-1:0] o_stage // stage outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    import cocs_pkg::*;

    cocs_stage_s [NSTAGE-1:0] held_r;
    logic [CUR_W-1:0] junk_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held_r <= '0;
            junk_r <= 16'h5a5a;
        end else begin
            junk_r <= ~junk_r + 16'h0001;
            if (i_cmd_en) begin
                held_r[i_cmd_idx] <= i_cmd;
            end
        end
    end

    // idle stage current carries no meaning: show a moving pattern
    always_comb begin
        for (int k = 0; k < NSTAGE; k++) begin
            o_stage[k] = held_r[k];
            if (held_r[k].start == 3'h0 && held_r[k].trip == 3'h0) begin
                o_stage[k].current = junk_r ^ k[15:0];
            end
        end
    end
endmodule // cocs_stage_model

// ---- tb/cocs_top_tb.sv ----
module cocs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cocs_pkg::*;
    localparam int TICK = 4;

    logic clk, rst_n, wr_en, rd_en, cmd_en;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data, d;
    logic [2:0] cmd_idx;
    cocs_stage_s cmd;
    cocs_stage_s [NSTAGE-1:0] stage;
    cocs_event_s ev;
    cocs_matrix_s mx;
    cocs_fault_type_s ft;
    logic [15:0] acur, lf, ev_cur;
    logic ashow;
    logic [16:0] ev_acc;
    int miscompares = 0;
    int cmp_count = 0;
    int n;

    cocs_stage_model u_model (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cmd_en(cmd_en),
        .i_cmd_idx(cmd_idx), .i_cmd(cmd), .o_stage(stage));
    cocs_top #(.TICK_CYC(TICK)) dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_stage(stage),
        .i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .o_rd_data(rd_data), .o_event(ev), .o_matrix(mx), .o_fault_type(ft),
        .o_alarm_current(acur), .o_alarm_show(ashow));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // gathers event masks between two stimulus steps
    always @(posedge clk) begin
        if (ev.valid === 1'b1) begin
            ev_acc <= ev_acc | ev.mask;
            ev_cur <= ev.current;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] exp_status(input logic [2:0] st, input logic [2:0] tr);
        return {|tr, tr, |st, st};
    endfunction

    function automatic logic [7:0] exp_mx(input logic [2:0] st, input logic [2:0] tr);
        return {|tr, |st, tr, st};
    endfunction

    task automatic finish_test();
        $display("compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
        chk(d, exp, what);
    endtask

    // loads one stage, clears the event record, then waits w cycles
    task automatic drive(input int idx, input logic [2:0] st, input logic [2:0] tr,
                         input logic [15:0] cur, input int w);
        @(posedge clk);
        cmd_en <= 1'b1;
        cmd_idx <= idx[2:0];
        cmd <= {st, tr, cur};
        // clear off the edge so the collector cannot race it
        #1 ev_acc = '0;
        @(posedge clk);
        cmd_en <= 1'b0;
        repeat (w) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        {wr_en, rd_en, cmd_en, addr, wr_data, cmd_idx, cmd} = '0;
        ev_acc = '0;
        ev_cur = '0;
        lf = 16'h0031;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(OFS_CTRL, {9'h0, CTRL_RESET}, "ctrl reset");
        rdchk(OFS_CLEARING_DELAY, 32'h0, "delay reset");
        rdchk(8'h14, 32'h0, "unmapped read");
        wr(OFS_STATUS, 32'hff);
        rdchk(OFS_STATUS, 32'h0, "status read only");
        $display("test reset done");

        drive(0, 3'b001, 3'b000, 16'h0064, 4);
        rdchk(OFS_STATUS, exp_status(3'b001, 3'b000), "start status");
        chk(mx, exp_mx(3'b001, 3'b000), "start matrix");
        chk(ev_acc, 17'h00041, "start rise events");
        chk(ev_cur, 32'h64, "event current");
        chk(ft, 5'b01001, "start fault type");
        chk({ashow, acur}, {1'b1, 16'h0064}, "alarm screen");
        rdchk(OFS_LAST_FAULT_CURRENT, 32'h64, "last current");
        drive(0, 3'b000, 3'b000, 16'h0000, 4);
        chk(mx, 8'h0, "matrix released");
        chk(ev_acc, 17'h00088, "start fall events");
        $display("test start done");

        drive(5, 3'b000, 3'b110, 16'h00c8, 4);
        rdchk(OFS_STATUS, exp_status(3'b000, 3'b110), "trip status");
        chk(mx, exp_mx(3'b000, 3'b110), "trip matrix");
        chk(ev_acc, 17'h04600, "trip rise events");
        chk(ft, 5'b10110, "trip fault type");
        drive(5, 3'b000, 3'b000, 16'h0000, 4);
        chk(ev_acc, 17'h0b000, "trip fall events");
        wr(OFS_LAST_FAULT_CURRENT, 32'h5);
        rdchk(OFS_LAST_FAULT_CURRENT, 32'h5, "soft last current");
        chk({ashow, acur}, {1'b0, 16'h0005}, "alarm not largest");
        $display("test trip done");

        wr(OFS_CTRL, {9'h0, CTRL_RESET & ~23'h5});
        drive(1, 3'b111, 3'b000, 16'h0032, 4);
        chk(ev_acc, 17'h0, "rise disabled");
        drive(1, 3'b000, 3'b000, 16'h0000, 4);
        chk(ev_acc, 17'h000b8, "fall all phases");
        wr(OFS_CTRL, {9'h0, CTRL_RESET & ~(23'h1 << 20)});
        drive(4, 3'b111, 3'b111, 16'h012c, 4);
        rdchk(OFS_STATUS, 32'h0, "disabled stage");
        chk(mx, 8'h0, "disabled matrix");
        drive(4, 3'b000, 3'b000, 16'h0000, 4);
        $display("test enables done");

        for (int s = 0; s < 2; s++) begin
            wr(OFS_CTRL, {9'h0, CTRL_RESET | (23'(s) << 8)});
            drive(2, 3'b001, 3'b000, 16'h0064, 4);
            drive(2, 3'b001, 3'b000, 16'h012c, 4);
            chk(ev_acc[16], s == 0, "growing event");
            rdchk(OFS_LAST_FAULT_CURRENT, 32'h12c, "grown current");
            drive(2, 3'b000, 3'b000, 16'h0000, 4);
        end
        $display("test growing done");

        wr(OFS_CLEARING_DELAY, 32'hffff);
        rdchk(OFS_CLEARING_DELAY, 32'hffff, "delay max");
        wr(OFS_CLEARING_DELAY, 32'h2);
        drive(3, 3'b010, 3'b000, 16'h0050, 4);
        drive(3, 3'b000, 3'b000, 16'h0000, 0);
        n = 0;
        while (mx !== 8'h0) begin
            @(posedge clk);
            #1 n++;
            if (n > 100) begin
                miscompares++;
                finish_test();
            end
        end
        chk(n >= 2 * TICK && n <= 2 * TICK + 4, 1'b1, "clearing delay hold");
        wr(OFS_CLEARING_DELAY, 32'h0);
        $display("test delay done");

        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            drive(lf % 7, lf[2:0], lf[5:3], {lf[15:6], 6'h1}, 4);
            rdchk(OFS_STATUS, exp_status(lf[2:0], lf[5:3]), "random status");
            chk(mx, exp_mx(lf[2:0], lf[5:3]), "random matrix");
            drive(lf % 7, 3'b000, 3'b000, 16'h0000, 4);
            chk(mx, 8'h0, "random release");
        end
        $display("test random done");
        finish_test();
    end
endmodule // cocs_top_tb
